/* File: design/acb_pkg.sv */
// Purpose: shared constants and types for the capture bridge
// Assumes: one clock, registers on a plain strobe port
// Notes: marker patterns are right-aligned in a 12-bit field
package acb_pkg;
  localparam int IN_W = 128;
  localparam int OUT_W = 256;
  localparam int LANE_W = 16;
  localparam int DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;
  localparam logic [CNT_W-1:0] BURST_WORDS = 4'h4;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_FLUSH = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STAT = 4'h8;
  localparam int CB_HUNT = 0;
  localparam int CB_CAPTURE = 1;
  localparam int CB_TRIGGER_CONNECTOR_EN = 2;
  localparam int CB_CONV_LO = 4;
  localparam int FB_CLEAR = 2;
  localparam int MK_W = 12;
  localparam logic [MK_W-1:0] MK_TWO_WIRE = 12'h0f0;
  localparam logic [MK_W-1:0] MK_ONE_WIRE = 12'hfc0;
  localparam logic [MK_W-1:0] MK_ALT_WIRE = 12'h0e3;
  localparam logic [MK_W-1:0] MK_ALT_WIRE_B = 12'h038;
  localparam logic [MK_W-1:0] MASK_8 = 12'h0ff;
  localparam logic [MK_W-1:0] MASK_12 = 12'hfff;
  localparam logic [1:0] CONV_TWO = 2'h0;
  localparam logic [1:0] CONV_ONE = 2'h1;
  localparam logic [1:0] CONV_ALT = 2'h2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  typedef struct packed {
    logic [1:0] conv;
    logic trigger_connector_en;
    logic capture;
    logic hunt;
  } acb_ctrl_t;
  typedef struct packed {
    logic overflow;
    logic armed;
    logic cap_ok;
    logic burst_ready;
    logic [CNT_W-1:0] level;
  } acb_stat_t;
endpackage

/* File: design/acb_mem.sv */
// Purpose: word store for the capture bridge
// Assumes: one write and one read port on the same clock
// Notes: read data come out of a register, one cycle after rd_en
`timescale 1ns/1ps
module acb_mem import acb_pkg::*; (
  input wire logic clk, // clock
  input wire logic ce, // clock enable
  input wire logic wr_en, // write strobe
  input wire logic [PTR_W-1:0] wr_addr, // write address
  input wire logic [OUT_W-1:0] wr_data, // write data
  input wire logic rd_en, // read strobe
  input wire logic [PTR_W-1:0] rd_addr, // read address
  output logic [OUT_W-1:0] rd_data_ff // registered read data
);
  logic [OUT_W-1:0] mem_ff [DEPTH];

  // no reset on the array itself: flush only moves pointers
  always_ff @(posedge clk) begin
    if (ce) begin
      if (wr_en) begin
        mem_ff[wr_addr] <= wr_data;
      end
      if (rd_en) begin
        rd_data_ff <= mem_ff[rd_addr];
      end
    end
  end
endmodule

/* File: design/acb_top.sv */
// Purpose: frame-hunt formatter and width-doubling capture buffer
// Assumes: samples, frame bits and sequencer signals share clk
// Notes: trigger pin is asynchronous and passes three flops
// Notes on behaviour
// - frame hunt puts marker words on output
// - hunt: one marker after each sample word
// - once locked, sample words only
// - clearing hunt stops markers at once
// - latch samples only at canonical marker alignment
// - marker width equals converter serialization factor
// - store nothing before capture command
// - trigger enabled: wait for trigger event
// - trigger alone insufficient; capture still needed
// - each request cycle pops one output word
// - burst ready when four words held
// - request is sequencer write AND ready
// - delayed clear bit empties the buffer
// - 128-bit words in, 256-bit words out
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module acb_top import acb_pkg::*; (
  input wire logic clk, // 100 MHz clock
  input wire logic reset, // synchronous reset, active high
  input wire logic ce, // clock enable, freezes state when low
  input wire logic [ADDR_W-1:0] reg_addr, // register address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  output logic [31:0] reg_rdata_ff, // read data, cycle after reg_rd
  input wire logic [IN_W-1:0] smp_data, // deserialized sample word
  input wire logic smp_valid, // sample word valid
  input wire logic [MK_W-1:0] frame_bits, // frame clock bits beside sample
  input wire logic trigger_connector, // external trigger pin, async
  input wire logic seq_write_req, // sequencer write request
  input wire logic ctrl_ready, // controller ready
  output logic [OUT_W-1:0] fifo_dout, // popped word, cycle after request
  output logic burst_ready_ff, // four or more words held
  output logic [IN_W-1:0] fmt_word_ff, // formatted word
  output logic fmt_valid_ff // formatted word valid
);
  function automatic logic [MK_W-1:0] marker_of(input logic [1:0] conv);
    case (conv)
      CONV_ONE: marker_of = MK_ONE_WIRE;
      CONV_ALT: marker_of = MK_ALT_WIRE;
      default: marker_of = MK_TWO_WIRE;
    endcase
  endfunction

  function automatic logic [MK_W-1:0] mask_of(input logic [1:0] conv);
    mask_of = (conv == CONV_ONE) ? MASK_12 : MASK_8;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register port
  acb_ctrl_t ctrl_ff, nxt_ctrl;
  logic clr_bit_ff, nxt_clr_bit;
  logic flush_ff, nxt_flush;
  logic [31:0] nxt_reg_rdata;
  acb_stat_t stat;
  logic overflow_ff, armed_ff, cap_ok;
  logic [CNT_W-1:0] count_ff;

  assign stat = '{overflow: overflow_ff, armed: armed_ff, cap_ok: cap_ok,
                  burst_ready: burst_ready_ff, level: count_ff};

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_clr_bit = clr_bit_ff;
    nxt_reg_rdata = 32'h0000_0000;
    nxt_flush = clr_bit_ff; // delayed copy of the clear bit
    if (reg_wr && reg_addr == OFS_CTRL) begin
      nxt_ctrl.hunt = reg_wdata[CB_HUNT];
      nxt_ctrl.capture = reg_wdata[CB_CAPTURE];
      nxt_ctrl.trigger_connector_en = reg_wdata[CB_TRIGGER_CONNECTOR_EN];
      nxt_ctrl.conv = reg_wdata[CB_CONV_LO +: 2];
    end
    if (reg_wr && reg_addr == OFS_FLUSH) begin
      nxt_clr_bit = reg_wdata[FB_CLEAR];
    end
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL: nxt_reg_rdata = {26'h0, ctrl_ff.conv, 1'b0, ctrl_ff.trigger_connector_en,
                                   ctrl_ff.capture, ctrl_ff.hunt};
        OFS_FLUSH: nxt_reg_rdata = 32'(clr_bit_ff) << FB_CLEAR;
        OFS_STAT: nxt_reg_rdata = 32'(stat);
        default: nxt_reg_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_ff <= acb_ctrl_t'(CTRL_RESET[$bits(acb_ctrl_t)-1:0]);
      clr_bit_ff <= 1'b0;
      flush_ff <= 1'b0;
      reg_rdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      ctrl_ff <= nxt_ctrl;
      clr_bit_ff <= nxt_clr_bit;
      flush_ff <= nxt_flush;
      reg_rdata_ff <= nxt_reg_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // formatter: markers interleave with samples while hunting
  logic marker_due_ff, nxt_marker_due;
  logic [IN_W-1:0] nxt_fmt_word;
  logic nxt_fmt_valid;
  logic aligned;
  logic [MK_W-1:0] mk_pat;
  logic [MK_W-1:0] fb_masked;

  assign mk_pat = marker_of(ctrl_ff.conv);
  assign fb_masked = frame_bits & mask_of(ctrl_ff.conv);
  // rotations may lock the host, but data is taken only at the canonical one
  // the alternate part has two canonical alignments
  assign aligned = (fb_masked == mk_pat) ||
                   (ctrl_ff.conv == CONV_ALT && fb_masked == MK_ALT_WIRE_B);

  always_comb begin
    nxt_marker_due = marker_due_ff;
    nxt_fmt_word = fmt_word_ff;
    nxt_fmt_valid = 1'b0;
    if (!ctrl_ff.hunt) begin
      nxt_marker_due = 1'b0;
    end
    if (ctrl_ff.hunt && marker_due_ff) begin
      nxt_fmt_word = {(IN_W / LANE_W){4'h0, mk_pat}};
      nxt_fmt_valid = 1'b1;
      nxt_marker_due = 1'b0;
    end else if (smp_valid && aligned) begin
      nxt_fmt_word = smp_data;
      nxt_fmt_valid = 1'b1;
      nxt_marker_due = ctrl_ff.hunt;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      marker_due_ff <= 1'b0;
      fmt_word_ff <= '0;
      fmt_valid_ff <= 1'b0;
    end else if (ce) begin
      marker_due_ff <= nxt_marker_due;
      fmt_word_ff <= nxt_fmt_word;
      fmt_valid_ff <= nxt_fmt_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger synchroniser and capture gate
  logic [2:0] tsync_ff;
  logic trigger_connector_lvl_ff, nxt_trigger_connector_lvl;
  logic nxt_armed;
  logic cap_prev_ff;
  logic trigger_connector_event;

  assign trigger_connector_event = nxt_trigger_connector_lvl && !trigger_connector_lvl_ff;
  assign cap_ok = ctrl_ff.capture && (!ctrl_ff.trigger_connector_en || armed_ff);

  always_comb begin
    nxt_trigger_connector_lvl = trigger_connector_lvl_ff;
    // a change counts only once stages two and three agree
    if (tsync_ff[1] == tsync_ff[2]) begin
      nxt_trigger_connector_lvl = tsync_ff[2];
    end
    nxt_armed = armed_ff;
    if (flush_ff || (cap_prev_ff && !ctrl_ff.capture)) begin
      nxt_armed = 1'b0;
    end
    if (trigger_connector_event && ctrl_ff.trigger_connector_en) begin
      nxt_armed = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tsync_ff <= 3'h0;
      trigger_connector_lvl_ff <= 1'b0;
      armed_ff <= 1'b0;
      cap_prev_ff <= 1'b0;
    end else if (ce) begin
      tsync_ff <= {tsync_ff[1:0], trigger_connector};
      trigger_connector_lvl_ff <= nxt_trigger_connector_lvl;
      armed_ff <= nxt_armed;
      cap_prev_ff <= ctrl_ff.capture;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // buffer: two input words pair into one stored word, low word first
  logic half_ff, nxt_half;
  logic [IN_W-1:0] low_ff, nxt_low;
  logic [PTR_W-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
  logic [CNT_W-1:0] nxt_count;
  logic nxt_overflow, nxt_burst_ready;
  logic take, do_wr, do_rd, wdata_req;

  assign wdata_req = seq_write_req && ctrl_ready;
  assign take = fmt_valid_ff && cap_ok;
  assign do_wr = take && half_ff && (count_ff != CNT_FULL);
  assign do_rd = wdata_req && (count_ff != '0) && !flush_ff;

  always_comb begin
    nxt_half = half_ff;
    nxt_low = low_ff;
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_count = count_ff;
    nxt_overflow = overflow_ff;
    if (take) begin
      nxt_half = !half_ff;
      nxt_low = half_ff ? low_ff : fmt_word_ff;
      // full buffer has no way to stall the converter, so the pair is lost
      if (half_ff && count_ff == CNT_FULL) begin
        nxt_overflow = 1'b1;
      end
    end
    if (do_wr) begin
      nxt_wr_ptr = wr_ptr_ff + PTR_W'(1);
    end
    if (do_rd) begin
      nxt_rd_ptr = rd_ptr_ff + PTR_W'(1);
    end
    nxt_count = count_ff + CNT_W'(do_wr) - CNT_W'(do_rd);
    if (flush_ff) begin
      nxt_half = 1'b0;
      nxt_wr_ptr = '0;
      nxt_rd_ptr = '0;
      nxt_count = '0;
      nxt_overflow = 1'b0;
    end
    nxt_burst_ready = nxt_count >= BURST_WORDS;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      half_ff <= 1'b0;
      low_ff <= '0;
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      overflow_ff <= 1'b0;
      burst_ready_ff <= 1'b0;
    end else if (ce) begin
      half_ff <= nxt_half;
      low_ff <= nxt_low;
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
      overflow_ff <= nxt_overflow;
      burst_ready_ff <= nxt_burst_ready;
    end
  end

  acb_mem u_mem (
    .clk(clk),
    .ce(ce),
    .wr_en(do_wr),
    .wr_addr(wr_ptr_ff),
    .wr_data({fmt_word_ff, low_ff}),
    .rd_en(do_rd),
    .rd_addr(rd_ptr_ff),
    .rd_data_ff(fifo_dout)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_sample_in_hunt;
    ce && ctrl_ff.hunt && !marker_due_ff && smp_valid && aligned;
  endsequence
  sequence s_marker_out;
    fmt_valid_ff && fmt_word_ff[MK_W-1:0] == mk_pat;
  endsequence

  chk_marker_follows: assert property (@(posedge clk) disable iff (reset)
    s_sample_in_hunt ##1 (ce && ctrl_ff.hunt) |=> s_marker_out)
    else $error("no marker after sample in hunt");
  chk_no_marker_lock: assert property (@(posedge clk) disable iff (reset)
    (ce && !ctrl_ff.hunt && !(smp_valid && aligned)) |=> !fmt_valid_ff)
    else $error("marker emitted after lock");
  chk_align_only: assert property (@(posedge clk) disable iff (reset)
    (ce && !(ctrl_ff.hunt && marker_due_ff) && smp_valid && !aligned) |=> !fmt_valid_ff)
    else $error("sample taken off alignment");
  chk_no_early_store: assert property (@(posedge clk) disable iff (reset)
    (ce && !ctrl_ff.capture && !flush_ff) |=> (count_ff <= $past(count_ff)))
    else $error("stored before capture");
  chk_trigger_connector_wait: assert property (@(posedge clk) disable iff (reset)
    (ce && ctrl_ff.trigger_connector_en && !armed_ff && !flush_ff) |=> (count_ff <= $past(count_ff)))
    else $error("stored before trigger");
  chk_pop_out: assert property (@(posedge clk) disable iff (reset)
    (ce && seq_write_req && ctrl_ready && count_ff != '0 && !flush_ff)
    |=> (rd_ptr_ff == $past(rd_ptr_ff) + PTR_W'(1)))
    else $error("request did not pop");
  chk_burst_level: assert property (@(posedge clk) disable iff (reset)
    burst_ready_ff == (count_ff >= BURST_WORDS))
    else $error("burst ready wrong");
  chk_flush_empty: assert property (@(posedge clk) disable iff (reset)
    (ce && flush_ff) |=> (count_ff == '0 && !burst_ready_ff && (!armed_ff || $past(trigger_connector_event))))
    else $error("flush left data");
  chk_trigger_connector_arms: assert property (@(posedge clk) disable iff (reset)
    (ce && ctrl_ff.trigger_connector_en && !flush_ff && $rose(tsync_ff[2]) && tsync_ff[1]) |=> armed_ff)
    else $error("trigger not armed");
endmodule

/* File: tb/acb_ctrl_model.sv */
// Purpose: controller-side model that drains the capture buffer
// Assumes: bench asks for one pop per cycle through want
// Notes: slow holds ready low, so requests stall instead of popping
`timescale 1ns/1ps
module acb_ctrl_model (
  input wire logic clk, // clock
  input wire logic reset, // synchronous reset
  input wire logic want, // bench asks for a pop
  input wire logic slow, // stall the controller
  output logic seq_write_req, // sequencer write request
  output logic ctrl_ready // controller ready
);
  always_ff @(posedge clk) begin
    if (reset) begin
      seq_write_req <= 1'b0;
      ctrl_ready <= 1'b0;
    end else begin
      seq_write_req <= want;
      ctrl_ready <= !slow;
    end
  end
endmodule

/* File: tb/acb_top_tb_top.sv */
// Purpose: self-checking bench for the capture bridge
// Assumes: ce high except during the frozen pop, words aligned to the converter marker except the rotated ones
// Notes: buffer level is judged through the status register
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module acb_top_tb_top import acb_pkg::*;;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata_ff;
  logic [IN_W-1:0] smp_data = 128'h0;
  logic smp_valid = 1'b0;
  logic [MK_W-1:0] frame_bits = 12'h0f0;
  logic trigger_connector = 1'b0;
  logic want = 1'b0;
  logic slow = 1'b0;
  logic seq_write_req;
  logic ctrl_ready;
  logic [OUT_W-1:0] fifo_dout;
  logic burst_ready_ff;
  logic [IN_W-1:0] fmt_word_ff;
  logic fmt_valid_ff;
  logic [31:0] st;
  logic [31:0] wseq = 32'h100;
  int num_errors = 0;
  int compares = 0;
  int n_fmt = 0;

  acb_top dut (.clk(clk), .reset(reset), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .smp_data(smp_data), .smp_valid(smp_valid), .frame_bits(frame_bits),
    .trigger_connector(trigger_connector), .seq_write_req(seq_write_req),
    .ctrl_ready(ctrl_ready), .fifo_dout(fifo_dout), .burst_ready_ff(burst_ready_ff),
    .fmt_word_ff(fmt_word_ff), .fmt_valid_ff(fmt_valid_ff));
  acb_ctrl_model u_ctrl (.clk(clk), .reset(reset), .want(want), .slow(slow),
    .seq_write_req(seq_write_req), .ctrl_ready(ctrl_ready));

  always #5 clk = ~clk;
  // counts formatted words so markers show up as extra pulses
  always @(posedge clk) begin
    if (fmt_valid_ff === 1'b1) n_fmt <= n_fmt + 1;
  end

  //////////////////////////////////////////////////////////////////////////////
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    st = reg_rdata_ff;
  endtask
  // back-to-back words, then settle time for pairing and level
  task push(input int n, input logic [11:0] fb);
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      smp_valid <= 1'b1;
      smp_data <= {4{wseq}};
      frame_bits <= fb;
      wseq = wseq + 32'h1;
      @(posedge clk);
    end
    smp_valid <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task pulse;
    @(posedge clk);
    trigger_connector <= 1'b1;
    repeat (4) @(posedge clk);
    trigger_connector <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task pop_one;
    repeat (2) @(posedge clk);
    want <= 1'b1;
    @(posedge clk);
    want <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task t_reset;
    wr(OFS_CTRL, 32'h2);
    push(2, MK_TWO_WIRE);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(OFS_STAT);
    `CHK("stat_rst", 32'h0, st)
    rd(OFS_CTRL);
    `CHK("ctrl_rst", CTRL_RESET, st)
    rd(4'hc);
    `CHK("unmapped", 32'h0, st)
  endtask
  task t_hunt(input logic [1:0] cv, input logic [11:0] pat, input logic [11:0] rot);
    int f0;
    wr(OFS_CTRL, {26'h0, cv, 4'h1});
    @(posedge clk);
    smp_valid <= 1'b1;
    smp_data <= 128'h1234;
    frame_bits <= pat;
    @(posedge clk);
    smp_valid <= 1'b0;
    @(negedge clk);
    `CHK("sample", {1'b1, 128'h1234}, {fmt_valid_ff, fmt_word_ff})
    @(negedge clk);
    `CHK("marker", {1'b1, {8{4'h0, pat}}}, {fmt_valid_ff, fmt_word_ff})
    // let the marker pulse reach the word counter first
    @(negedge clk);
    f0 = n_fmt;
    push(1, rot);
    `CHK("rotated", f0, n_fmt)
    // host takes the rotation as its lock point and ends the hunt
    wr(OFS_CTRL, {26'h0, cv, 4'h0});
    f0 = n_fmt;
    push(3, pat);
    `CHK("no_marker", f0 + 3, n_fmt)
    if (cv == CONV_ALT) begin
      f0 = n_fmt;
      push(1, MK_ALT_WIRE_B);
      `CHK("alt_form", f0 + 1, n_fmt)
    end
  endtask
  task t_capture;
    logic [31:0] w0;
    wr(OFS_FLUSH, 32'h4);
    wr(OFS_FLUSH, 32'h0);
    wr(OFS_CTRL, 32'h0);
    push(2, MK_TWO_WIRE);
    rd(OFS_STAT);
    `CHK("precap", 8'h00, st[7:0])
    wr(OFS_CTRL, 32'h2);
    w0 = wseq;
    push(6, MK_TWO_WIRE);
    rd(OFS_STAT);
    `CHK("three", 5'h03, st[4:0])
    push(2, MK_TWO_WIRE);
    rd(OFS_STAT);
    `CHK("four", 5'h14, st[4:0])
    `CHK("bready", 1'b1, burst_ready_ff)
    @(posedge clk);
    slow <= 1'b1;
    pop_one();
    rd(OFS_STAT);
    `CHK("stalled", 4'h4, st[3:0])
    @(posedge clk);
    ce <= 1'b0;
    pop_one();
    ce <= 1'b1;
    rd(OFS_STAT);
    `CHK("frozen", 4'h4, st[3:0])
    @(posedge clk);
    slow <= 1'b0;
    pop_one();
    `CHK("pop", {{4{w0 + 32'h1}}, {4{w0}}}, fifo_dout)
    rd(OFS_STAT);
    `CHK("after_pop", 5'h03, st[4:0])
    wr(OFS_FLUSH, 32'h4);
    wr(OFS_FLUSH, 32'h0);
    rd(OFS_STAT);
    `CHK("flushed", 5'h00, st[4:0])
    push(18, MK_TWO_WIRE);
    rd(OFS_STAT);
    `CHK("overflow", 6'h38, {st[7], st[4:0]})
    wr(OFS_FLUSH, 32'h4);
    wr(OFS_FLUSH, 32'h0);
    wr(OFS_CTRL, 32'h0);
  endtask
  task t_trigger_connector;
    wr(OFS_CTRL, 32'h6);
    push(2, MK_TWO_WIRE);
    rd(OFS_STAT);
    `CHK("wait_trigger_connector", 4'h0, st[3:0])
    pulse();
    rd(OFS_STAT);
    `CHK("armed", 1'b1, st[6])
    push(2, MK_TWO_WIRE);
    rd(OFS_STAT);
    `CHK("trigger_connector_cap", 4'h1, st[3:0])
    wr(OFS_CTRL, 32'h4);
    pulse();
    push(2, MK_TWO_WIRE);
    rd(OFS_STAT);
    `CHK("no_capture", 4'h1, st[3:0])
    wr(OFS_CTRL, 32'h6);
    push(2, MK_TWO_WIRE);
    rd(OFS_STAT);
    `CHK("late_cap", 4'h2, st[3:0])
    wr(OFS_FLUSH, 32'h4);
    // flush acts from the delayed copy, one cycle behind the write
    repeat (2) @(posedge clk);
    rd(OFS_STAT);
    `CHK("disarm", 6'h00, {st[6], st[4:0]})
    wr(OFS_FLUSH, 32'h0);
    wr(OFS_CTRL, 32'h0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task stop_test;
    if (num_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_hunt(CONV_TWO, MK_TWO_WIRE, 12'h0e1);
    t_hunt(CONV_ONE, MK_ONE_WIRE, 12'hf81);
    t_hunt(CONV_ALT, MK_ALT_WIRE, 12'h0c7);
    t_capture();
    t_trigger_connector();
    stop_test();
  end
  // whole run is a few hundred cycles; this is far beyond it
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end
endmodule
